// File: src/agc_pkg.sv
// Package for the general configuration and control register block.
// Assumes a 32-bit register port addressed by byte offset.
package agc_pkg;
	// Register byte offsets
	localparam logic [11:0] AGC_OFS_GENERAL_CONFIGURATION = 12'h080;
	localparam logic [11:0] AGC_OFS_GENERAL_CONTROL = 12'h088;
	localparam logic [11:0] AGC_OFS_INTERRUPT_REASON = 12'h098;
	// General configuration field positions
	localparam int AGC_CFG_EVLOG_BIT = 13;
	localparam int AGC_CFG_UMINT_BIT = 12;
	localparam int AGC_CFG_RBLIM_MSB = 7;
	// General control field positions
	localparam int AGC_CTL_EVLOG_BIT = 2;
	localparam int AGC_CTL_HALT_BIT = 1;
	localparam int AGC_CTL_SWERR_BIT = 0;
	// Interrupt reason field positions
	localparam int AGC_RSN_EVLOG_BIT = 5;
	localparam int AGC_RSN_HALT_BIT = 4;
	localparam int AGC_RSN_SWERR_BIT = 0;
	// Reset values
	localparam logic [31:0] AGC_CFG_RESET = 32'h0000_0000;
	localparam logic [31:0] AGC_CTL_RESET = 32'h0000_0000;
	localparam logic [31:0] AGC_RSN_RESET = 32'h0000_0000;
	// Device state field encodings
	typedef enum logic [1:0] {
		AGC_ST_DISABLED = 2'b00,
		AGC_ST_ENABLED = 2'b01,
		AGC_ST_DRAINING = 2'b10,
		AGC_ST_HALTED = 2'b11
	} agc_dev_state_t;
endpackage : agc_pkg

// File: src/agc_regs.sv
// General configuration, general control and interrupt reason registers.
// Assumes a single-cycle register port on core_clk; device state,
// capability flags and event strobes come from the surrounding core.
`timescale 1ns/1ps
module agc_regs
	import agc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic [1:0] dev_state,
	input wire logic cap_config_support,
	input wire logic cap_event_log_support,
	input wire logic cap_global_limit_support,
	input wire logic group_use_global_limit,
	input wire logic event_log_write,
	input wire logic swerr_valid,
	output logic event_log_enable,
	output logic user_int_enable,
	output logic [7:0] global_read_buffer_limit,
	output logic group_limit_active,
	output logic msix0_int
);

	logic [31:0] cfg_r, cfg_nxt;
	logic [2:0] ctl_r, ctl_nxt;
	logic [2:0] rsn_r, rsn_nxt;
	logic halted_r, halted_nxt;
	logic swv_r, swv_nxt;
	logic int_r, int_nxt;
	logic [31:0] rdata_nxt;
	logic cfg_we, ctl_we, rsn_we;
	logic halt_entry, swerr_rise, ev_hit, halt_hit, sw_hit;
	logic dev_disabled;

	// Every check below runs on the one core clock, muted in reset
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Event detection and gating by the control enables
	always_comb begin
		dev_disabled = (dev_state == AGC_ST_DISABLED);
		// Edges against last cycle, so a long halt sets its cause once
		halt_entry = (dev_state == AGC_ST_HALTED) && !halted_r;
		swerr_rise = swerr_valid && !swv_r;
		ev_hit = event_log_write && ctl_r[AGC_CTL_EVLOG_BIT];
		halt_hit = halt_entry && ctl_r[AGC_CTL_HALT_BIT];
		sw_hit = swerr_rise && ctl_r[AGC_CTL_SWERR_BIT];
		cfg_we = reg_wr && reg_addr == AGC_OFS_GENERAL_CONFIGURATION;
		ctl_we = reg_wr && reg_addr == AGC_OFS_GENERAL_CONTROL;
		rsn_we = reg_wr && reg_addr == AGC_OFS_INTERRUPT_REASON;
	end

	// Next register values; locked fields keep their value
	always_comb begin
		cfg_nxt = cfg_r;
		if (cfg_we && dev_disabled) begin
			if (cap_event_log_support) begin
				cfg_nxt[AGC_CFG_EVLOG_BIT] = reg_wdata[AGC_CFG_EVLOG_BIT];
			end
			if (cap_config_support) begin
				cfg_nxt[AGC_CFG_UMINT_BIT] = reg_wdata[AGC_CFG_UMINT_BIT];
				if (cap_global_limit_support) begin
					cfg_nxt[AGC_CFG_RBLIM_MSB:0] =
						reg_wdata[AGC_CFG_RBLIM_MSB:0];
				end
			end
		end
		// Control keeps only its three enables; the rest reads zero
		ctl_nxt = ctl_we ? reg_wdata[2:0] : ctl_r;
		// Set wins over a same-cycle write-one clear
		rsn_nxt = rsn_r;
		if (rsn_we) begin
			if (reg_wdata[AGC_RSN_EVLOG_BIT]) rsn_nxt[2] = 1'b0;
			if (reg_wdata[AGC_RSN_HALT_BIT]) rsn_nxt[1] = 1'b0;
			if (reg_wdata[AGC_RSN_SWERR_BIT]) rsn_nxt[0] = 1'b0;
		end
		if (ev_hit) rsn_nxt[2] = 1'b1;
		if (halt_hit) rsn_nxt[1] = 1'b1;
		if (sw_hit) rsn_nxt[0] = 1'b1;
		// Last levels, kept for the edge detectors
		halted_nxt = (dev_state == AGC_ST_HALTED);
		swv_nxt = swerr_valid;
		int_nxt = ev_hit || halt_hit || sw_hit;
	end

	// Write locks: a refused write leaves the field as it was
	a_cfg_locked: assert property (
		cfg_we && !dev_disabled |=> $stable(cfg_r))
		else $error("config changed while locked");
	a_nocap_lock: assert property (
		!cap_config_support |=> cfg_r[7:0] == $past(cfg_r[7:0]))
		else $error("limit changed without support");
	a_umint_lock: assert property (
		!cap_config_support |=> $stable(cfg_r[12]))
		else $error("user int bit changed");
	a_evlog_rsvd: assert property (
		!cap_event_log_support |=> $stable(cfg_r[13]))
		else $error("event log bit changed");
	a_limit_rsvd: assert property (
		!cap_global_limit_support |=> $stable(cfg_r[7:0]))
		else $error("limit field changed");
	a_cfg_write: assert property (
		cfg_we && dev_disabled && cap_config_support &&
		cap_global_limit_support |=>
		global_read_buffer_limit == $past(reg_wdata[7:0]))
		else $error("limit write lost");
	a_evlog_route: assert property (
		cfg_we && dev_disabled && cap_event_log_support |=>
		event_log_enable == $past(reg_wdata[13]))
		else $error("event log enable write lost");
	a_umint_write: assert property (
		cfg_we && dev_disabled && cap_config_support |=>
		user_int_enable == $past(reg_wdata[12]))
		else $error("user int enable write lost");

	// Causes: an enabled event pulses the line and sets its bit
	a_evlog_int: assert property (
		event_log_write && ctl_r[2] |=> msix0_int && rsn_r[2])
		else $error("event log int missing");
	a_halt_int: assert property (
		$rose(dev_state == AGC_ST_HALTED) && ctl_r[1] |=> rsn_r[1])
		else $error("halt cause missing");
	a_swerr_int: assert property (
		!swerr_valid ##1 swerr_valid && ctl_r[0] |=> msix0_int)
		else $error("swerr int missing");
	a_no_int: assert property (
		!ev_hit && !halt_hit && !sw_hit |=> !msix0_int)
		else $error("spurious interrupt");
	a_int_cause: assert property (
		msix0_int |-> rsn_r != 3'h0)
		else $error("interrupt without a cause");
	a_rsn_clear: assert property (
		rsn_we && reg_wdata[0] && !sw_hit |=> !rsn_r[0])
		else $error("swerr cause not cleared");
	a_halt_clear: assert property (
		rsn_we && reg_wdata[4] && !halt_hit |=> !rsn_r[1])
		else $error("halt cause not cleared");
	a_evlog_clear: assert property (
		rsn_we && reg_wdata[5] && !ev_hit |=> !rsn_r[2])
		else $error("event log cause not cleared");
	a_cause_hold: assert property (
		!rsn_we && !ev_hit |=> $stable(rsn_r[2]))
		else $error("event log cause lost");

	// Read mux; unmapped offsets and reserved bits read zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
				AGC_OFS_GENERAL_CONFIGURATION: rdata_nxt = cfg_r;
				AGC_OFS_GENERAL_CONTROL: rdata_nxt = {29'h0, ctl_r};
				AGC_OFS_INTERRUPT_REASON: rdata_nxt = {26'h0, rsn_r[2],
					rsn_r[1], 3'h0, rsn_r[0]};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Read side: reserved bits and idle cycles read zero
	a_rsvd_zero: assert property (
		reg_rd && reg_addr == AGC_OFS_GENERAL_CONFIGURATION |=>
		reg_rdata[31:14] == 18'h0 && reg_rdata[11:8] == 4'h0)
		else $error("reserved bits nonzero");
	a_ctl_rsvd: assert property (
		reg_rd && reg_addr == AGC_OFS_GENERAL_CONTROL |=>
		reg_rdata[31:3] == 29'h0)
		else $error("control reserved bits nonzero");
	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data without a read");

	// Main scenarios worth seeing once each
	c_cfg_write: cover property (cfg_we && dev_disabled);
	c_cfg_refused: cover property (cfg_we && !dev_disabled);
	c_evlog_int: cover property (ev_hit);
	c_halt_int: cover property (halt_hit);
	c_swerr_int: cover property (sw_hit);

	// State registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_r <= AGC_CFG_RESET;
			ctl_r <= AGC_CTL_RESET[2:0];
			rsn_r <= AGC_RSN_RESET[2:0];
			halted_r <= 1'b0;
			swv_r <= 1'b0;
			int_r <= 1'b0;
			reg_rdata <= 32'h0000_0000;
		end else begin
			cfg_r <= cfg_nxt;
			ctl_r <= ctl_nxt;
			rsn_r <= rsn_nxt;
			halted_r <= halted_nxt;
			swv_r <= swv_nxt;
			int_r <= int_nxt;
			reg_rdata <= rdata_nxt;
		end
	end

	// Outputs to the core; the limit only reaches flagged groups
	assign event_log_enable = cfg_r[AGC_CFG_EVLOG_BIT];
	assign user_int_enable = cfg_r[AGC_CFG_UMINT_BIT];
	assign global_read_buffer_limit = cfg_r[AGC_CFG_RBLIM_MSB:0];
	assign group_limit_active = group_use_global_limit &&
		cap_global_limit_support;
	assign msix0_int = int_r;

endmodule : agc_regs

// File: tb/agc_regs_tb.sv
// Self-checking bench for the configuration and control registers.
// Assumes agc_regs alone, inputs driven at falling edges of core_clk.
`timescale 1ns/1ps
module agc_regs_tb;
	import agc_pkg::*;
	localparam logic [11:0] cfg_a = AGC_OFS_GENERAL_CONFIGURATION;
	localparam logic [11:0] ctl_a = AGC_OFS_GENERAL_CONTROL;
	localparam logic [11:0] rsn_a = AGC_OFS_INTERRUPT_REASON;
	logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [1:0] dev_state = 2'b00;
	logic cap_config_support = 1'b1, cap_event_log_support = 1'b1;
	logic cap_global_limit_support = 1'b1, group_use_global_limit = 1'b0;
	logic event_log_write = 1'b0, swerr_valid = 1'b0, msix0_int;
	logic event_log_enable, user_int_enable, group_limit_active;
	logic [7:0] global_read_buffer_limit;
	int fail_count = 0, checked = 0;
	// 50 MHz core clock
	always #10 core_clk = ~core_clk;
	agc_regs agc_regs_i (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .dev_state, .cap_config_support,
		.cap_event_log_support, .cap_global_limit_support,
		.group_use_global_limit, .event_log_write, .swerr_valid,
		.event_log_enable, .user_int_enable, .global_read_buffer_limit,
		.group_limit_active, .msix0_int);
	// Case equality so an unknown never counts as a match
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One-cycle write strobe; a gap cycle follows every access
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge core_clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge core_clk);
		reg_wr = 1'b0;
	endtask : wr
	// Read data stands for one cycle after the strobe is taken
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		@(negedge core_clk);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge core_clk);
		reg_rd = 1'b0;
		chk(reg_rdata, exp);
	endtask : rdc
	// Raise one event kind; the line pulses exactly once, or not at all
	task automatic fire(input int k, input logic exp);
		int pulses;
		pulses = 0;
		@(negedge core_clk);
		event_log_write = (k == 0);
		if (k == 1) dev_state = 2'b11;
		if (k == 2) swerr_valid = 1'b1;
		@(negedge core_clk);
		event_log_write = 1'b0;
		pulses = int'(msix0_int === 1'b1);
		repeat (3) begin
			@(negedge core_clk);
			pulses += int'(msix0_int === 1'b1);
		end
		chk(pulses, {31'h0, exp});
	endtask : fire
	task automatic t_cfg();
		wr(cfg_a, 32'hffff_ffff);
		rdc(cfg_a, 32'h0000_30ff);
		chk({22'h0, event_log_enable, user_int_enable,
			global_read_buffer_limit}, 32'h0000_03ff);
		dev_state = 2'b01;
		wr(cfg_a, 32'h0);
		rdc(cfg_a, 32'h0000_30ff);
		dev_state = 2'b10;
		wr(cfg_a, 32'h0);
		rdc(cfg_a, 32'h0000_30ff);
		dev_state = 2'b00;
	endtask : t_cfg
	task automatic t_caps();
		cap_config_support = 1'b0;
		wr(cfg_a, 32'h0);
		rdc(cfg_a, 32'h0000_10ff);
		cap_config_support = 1'b1;
		wr(cfg_a, 32'h0);
		cap_event_log_support = 1'b0;
		cap_global_limit_support = 1'b0;
		wr(cfg_a, 32'h0000_20ff);
		rdc(cfg_a, 32'h0);
		cap_event_log_support = 1'b1;
	endtask : t_caps
	task automatic t_limit();
		for (int i = 0; i < 4; i++) begin
			@(negedge core_clk);
			group_use_global_limit = i[0];
			cap_global_limit_support = i[1];
			@(posedge core_clk);
			chk({31'h0, group_limit_active}, {31'h0, i[0] & i[1]});
		end
	endtask : t_limit
	task automatic t_irq();
		wr(ctl_a, 32'hffff_ffff);
		rdc(ctl_a, 32'h0000_0007);
		fire(0, 1'b1);
		fire(1, 1'b1);
		fire(2, 1'b1);
		rdc(rsn_a, 32'h0000_0031);
		wr(rsn_a, 32'h0000_0010);
		rdc(rsn_a, 32'h0000_0021);
		wr(rsn_a, 32'hffff_ffff);
		rdc(rsn_a, 32'h0);
		wr(cfg_a, 32'hffff_ffff);
		rdc(cfg_a, 32'h0);
		dev_state = 2'b00;
		swerr_valid = 1'b0;
		wr(ctl_a, 32'h0);
		fire(0, 1'b0);
		fire(1, 1'b0);
		fire(2, 1'b0);
		rdc(rsn_a, 32'h0);
		rdc(12'h0a0, 32'h0);
	endtask : t_irq
	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	// Reset held 16 cycles, released away from the sampling edge
	initial begin
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		rdc(cfg_a, AGC_CFG_RESET);
		rdc(ctl_a, AGC_CTL_RESET);
		t_cfg();
		t_caps();
		t_limit();
		t_irq();
		tally_and_finish();
	end
endmodule : agc_regs_tb
